// [shared/rwm_pkg.sv]
// Constants, register map and carrier types of the reset supervisor.
// Assumes a 10 MHz ref_clk that also serves as the bus clock.

package rwm_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_SYSTEM_SETTINGS = 4'h0;
   localparam logic [3:0] OFS_NONVOLATILE_SETUP = 4'h4;
   localparam logic [3:0] OFS_WATCHDOG_SERVICE = 4'h8;
   localparam logic [3:0] OFS_TEST_CONTROL_ONE = 4'hC;

   // Field positions
   localparam int POS_IRQ_EDGE = 5;
   localparam int POS_CLK_FAIL_EN = 3;
   localparam int POS_RATE_LO = 0;
   localparam int POS_WD_DISABLE = 2;
   localparam int POS_RESET_INHIBIT = 2;

   // Reset values
   localparam logic [7:0] RST_SYSTEM_SETTINGS = 8'h00;
   localparam logic [7:0] RST_NONVOLATILE_SETUP = 8'h00;

   // Service codes
   localparam logic [7:0] SERVICE_ARM = 8'h55;
   localparam logic [7:0] SERVICE_CLEAR = 8'hAA;

   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int POWER_UP_CYCLES = 4064;
   localparam int PIN_DRIVE_CYCLES = 4;
   localparam int PIN_SAMPLE_CYCLES = 2;
   localparam int RATE_WRITE_WINDOW = 64;
   localparam int WATCHDOG_DIV_LOG2 = 15;
   // Failure is flagged for clock below this rate
   localparam int MONITOR_MIN_HZ = 10_000;
   // Monitor delay in ns, between 1/200 kHz and 1/10 kHz
   localparam int MONITOR_DELAY_NS = 20_000;

   // Reset causes, in vector groups
   typedef enum logic [1:0] {
      RWM_CAUSE_PIN,
      RWM_CAUSE_CLOCK_FAIL,
      RWM_CAUSE_WATCHDOG
   } rwm_cause_type;

   // Bus request carrier
   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } rwm_bus_req_type;

endpackage

// [src/rwm_clock_monitor.sv]
// Stopped or slow clock detector built as a delay line model.
// Assumes monitor_tick is a free running reference independent of ref_clk.
`timescale 1ns/1ns

module rwm_clock_monitor #(
   parameter int DELAY_TICKS = 20
) (
   // Reference tick domain
   input wire logic monitor_tick,
   // Watched clock
   input wire logic ref_clk,
   input wire logic enable,
   // Result
   output logic clock_fail
);

   // A round trip of the ping takes about three ticks at full speed
   initial begin
      if (DELAY_TICKS < 4 || DELAY_TICKS > 255)
         $error("DELAY_TICKS out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Ping sent from the tick domain, echoed back by the watched clock.
   // A handshake cannot alias when the two rates are whole multiples.
   logic ping = 1'b0;
   logic ping_a = 1'b0;
   logic ping_b = 1'b0;
   logic echo_a = 1'b0;
   logic echo_b = 1'b0;
   logic en_a = 1'b0;
   logic en_b = 1'b0;
   logic [7:0] count = 8'h00;
   logic expired = 1'b0;
   logic fail_a = 1'b0;
   logic fail_b = 1'b0;

   // Echo path through two flops of the watched clock
   always_ff @(posedge ref_clk) begin
      ping_a <= ping;
      ping_b <= ping_a;
   end

   // Echo and enable seen through two flops in the tick domain
   always_ff @(posedge monitor_tick) begin
      echo_a <= ping_b;
      echo_b <= echo_a;
      en_a <= enable;
      en_b <= en_a;
   end

   // A returned echo sends the next ping
   always_ff @(posedge monitor_tick) begin
      if (echo_b == ping)
         ping <= ~ping;
   end

   // Count ticks while a ping is outstanding; works without ref_clk
   always_ff @(posedge monitor_tick) begin
      if (!en_b || echo_b == ping)
         count <= 8'h00;
      else if (count != 8'(DELAY_TICKS))
         count <= count + 8'h01;
   end

   always_ff @(posedge monitor_tick) begin
      expired <= en_b && count == 8'(DELAY_TICKS);
   end

   // Failure carried into the watched domain; the reset needs that clock
   always_ff @(posedge ref_clk) begin
      fail_a <= expired;
      fail_b <= fail_a;
   end

   assign clock_fail = enable && fail_b;

endmodule

// [src/rwm_supervisor.sv]
// Reset supervisor: power-up delay, reset pin, watchdog, clock monitor.
// Assumes Avalon-MM register access and an open-drain reset pin.
`timescale 1ns/1ns

module rwm_supervisor #(
   parameter int POWER_UP_CYCLES = rwm_pkg::POWER_UP_CYCLES,
   parameter int WATCHDOG_DIV_LOG2 = rwm_pkg::WATCHDOG_DIV_LOG2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic monitor_tick,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Reset pin, open drain
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   // Processor side
   input wire logic special_mode,
   input wire logic stop_request,
   output logic cpu_reset,
   output logic [1:0] reset_cause,
   output logic irq_edge_select
);

   localparam int MON_TICKS =
      rwm_pkg::MONITOR_DELAY_NS / 1000;

   initial begin
      if (POWER_UP_CYCLES < 8 || POWER_UP_CYCLES > 65535)
         $error("POWER_UP_CYCLES out of range");
      if (WATCHDOG_DIV_LOG2 < 1 || WATCHDOG_DIV_LOG2 > 20)
         $error("WATCHDOG_DIV_LOG2 out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state
   typedef enum logic [2:0] {
      ST_POWER_UP,
      ST_DRIVE,
      ST_SETTLE,
      ST_HOLD,
      ST_RUN
   } rwm_state_type;

   rwm_state_type state;
   logic [15:0] seq_count;
   logic power_done;
   rwm_pkg::rwm_cause_type pend_cause;
   logic [7:0] settings;
   logic [7:0] nv_setup;
   logic watchdog_active;
   logic reset_inhibit;
   logic rate_written;
   logic [6:0] run_count;
   logic armed;
   logic [26:0] wd_count;
   logic wd_timeout;
   logic clock_fail;
   logic stop_fail;
   logic internal_event;
   logic read_done;

   // Access decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   // Reads wait one cycle so the registered data stand at the answer
   assign waitrequest = read && !read_done;
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         read_done <= 1'b0;
      else
         read_done <= read && !read_done;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock monitor
   rwm_clock_monitor #(
      .DELAY_TICKS(MON_TICKS)
   ) u_mon (
      .monitor_tick(monitor_tick),
      .ref_clk(ref_clk),
      .enable(settings[rwm_pkg::POS_CLK_FAIL_EN] && state == ST_RUN),
      .clock_fail(clock_fail)
   );

   // Stop with the monitor on halts the clock, so treat it as a failure
   assign stop_fail = stop_request
      && settings[rwm_pkg::POS_CLK_FAIL_EN];

   assign internal_event = state == ST_RUN
      && (clock_fail || stop_fail || wd_timeout);

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ST_POWER_UP;
         seq_count <= 16'h0000;
         power_done <= 1'b0;
         pend_cause <= rwm_pkg::RWM_CAUSE_PIN;
      end else begin
         unique case (state)
            ST_POWER_UP: begin
               if (seq_count == 16'(POWER_UP_CYCLES - 1)) begin
                  seq_count <= 16'h0000;
                  power_done <= 1'b1;
                  state <= ST_DRIVE;
               end else begin
                  seq_count <= seq_count + 16'h0001;
               end
            end
            ST_DRIVE: begin
               if (seq_count == 16'(rwm_pkg::PIN_DRIVE_CYCLES - 1)) begin
                  seq_count <= 16'h0000;
                  state <= ST_SETTLE;
               end else begin
                  seq_count <= seq_count + 16'h0001;
               end
            end
            ST_SETTLE: begin
               if (seq_count == 16'(rwm_pkg::PIN_SAMPLE_CYCLES - 1)) begin
                  seq_count <= 16'h0000;
                  // Low pin means someone outside holds reset
                  if (!reset_pin_in) begin
                     pend_cause <= rwm_pkg::RWM_CAUSE_PIN;
                     state <= ST_HOLD;
                  end else begin
                     state <= ST_RUN;
                  end
               end else begin
                  seq_count <= seq_count + 16'h0001;
               end
            end
            ST_HOLD: begin
               if (reset_pin_in)
                  state <= ST_RUN;
            end
            ST_RUN: begin
               // Priority: pin, clock monitor, watchdog
               if (!reset_pin_in) begin
                  pend_cause <= rwm_pkg::RWM_CAUSE_PIN;
                  state <= ST_DRIVE;
               end else if (clock_fail || stop_fail) begin
                  pend_cause <= rwm_pkg::RWM_CAUSE_CLOCK_FAIL;
                  state <= ST_DRIVE;
               end else if (wd_timeout) begin
                  pend_cause <= rwm_pkg::RWM_CAUSE_WATCHDOG;
                  state <= ST_DRIVE;
               end
            end
            default: state <= ST_POWER_UP;
         endcase
      end
   end

   // Open-drain pin: only ever drives low
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = (state == ST_DRIVE);

   // Processor held in reset until the sequencer runs
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         cpu_reset <= 1'b1;
      else
         cpu_reset <= !(state == ST_RUN || (state == ST_HOLD
            && reset_pin_in)) || internal_event;
   end

   // Cause reported for vector selection
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         reset_cause <= 2'h0;
      else
         reset_cause <= pend_cause;
   end

   ////////////////////////////////////////////////////////////////////////
   // Option register and its write-once window
   always_ff @(posedge ref_clk) begin
      if (!rst_n || state != ST_RUN)
         run_count <= 7'h00;
      else if (run_count != 7'(rwm_pkg::RATE_WRITE_WINDOW))
         run_count <= run_count + 7'h01;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || (state != ST_RUN && state != ST_HOLD)) begin
         settings <= rwm_pkg::RST_SYSTEM_SETTINGS;
         rate_written <= 1'b0;
      end else if (write && hit(address, rwm_pkg::OFS_SYSTEM_SETTINGS))
      begin
         settings[rwm_pkg::POS_CLK_FAIL_EN] <=
            writedata[rwm_pkg::POS_CLK_FAIL_EN];
         settings[rwm_pkg::POS_IRQ_EDGE] <=
            writedata[rwm_pkg::POS_IRQ_EDGE];
         if (special_mode || (!rate_written
            && run_count < 7'(rwm_pkg::RATE_WRITE_WINDOW))) begin
            settings[1:0] <= writedata[1:0];
            rate_written <= 1'b1;
         end
      end
   end

   assign irq_edge_select = settings[rwm_pkg::POS_IRQ_EDGE];

   ////////////////////////////////////////////////////////////////////////
   // Nonvolatile setup: stored value, enable latched only at reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         nv_setup <= rwm_pkg::RST_NONVOLATILE_SETUP;
      else if (write && hit(address, rwm_pkg::OFS_NONVOLATILE_SETUP))
         nv_setup <= writedata[7:0];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         watchdog_active <= 1'b0;
      else if (state == ST_DRIVE)
         watchdog_active <= !nv_setup[rwm_pkg::POS_WD_DISABLE];
   end

   // Test inhibit starts set in special modes
   always_ff @(posedge ref_clk) begin
      if (!rst_n || state == ST_DRIVE)
         reset_inhibit <= 1'b0;
      else if (state == ST_SETTLE)
         reset_inhibit <= special_mode;
      else if (write && hit(address, rwm_pkg::OFS_TEST_CONTROL_ONE)
         && special_mode)
         reset_inhibit <= writedata[rwm_pkg::POS_RESET_INHIBIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog counter and service sequence
   logic [26:0] wd_limit;
   always_comb begin
      wd_limit = 27'(1) << (WATCHDOG_DIV_LOG2 + 2 * 32'(settings[1:0]));
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || state != ST_RUN)
         armed <= 1'b0;
      else if (write && hit(address, rwm_pkg::OFS_WATCHDOG_SERVICE)) begin
         if (writedata[7:0] == rwm_pkg::SERVICE_ARM)
            armed <= 1'b1;
         else if (writedata[7:0] == rwm_pkg::SERVICE_CLEAR)
            armed <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || state != ST_RUN)
         wd_count <= 27'h0000000;
      else if (write && hit(address, rwm_pkg::OFS_WATCHDOG_SERVICE)
         && armed && writedata[7:0] == rwm_pkg::SERVICE_CLEAR)
         wd_count <= 27'h0000000;
      else
         wd_count <= wd_count + 27'h0000001;
   end

   assign wd_timeout = watchdog_active && !reset_inhibit
      && wd_count >= wd_limit - 27'h0000001;

   ////////////////////////////////////////////////////////////////////////
   // Read data
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         readdata <= 32'h00000000;
      else if (read && !read_done) begin
         readdata <= 32'h00000000;
         if (hit(address, rwm_pkg::OFS_SYSTEM_SETTINGS))
            readdata[7:0] <= settings & 8'hEB;
         else if (hit(address, rwm_pkg::OFS_NONVOLATILE_SETUP))
            readdata[7:0] <= nv_setup;
         else if (hit(address, rwm_pkg::OFS_TEST_CONTROL_ONE))
            readdata[rwm_pkg::POS_RESET_INHIBIT] <= reset_inhibit;
      end
   end

endmodule

// [testbench/rwm_properties.sv]
// Port assertions for the reset supervisor.
// Assumes it is bound into rwm_supervisor with one clock domain.
`timescale 1ns/1ns
module rwm_properties #(
   parameter int POWER_UP_CYCLES = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Pin and processor side
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic stop_request,
   input wire logic cpu_reset,
   input wire logic irq_edge_select
);
   int up;
   logic clock_fail_detect_enable;
   ////////////////////////////////////////////////////////////////////////
   // Cycles since reset release
   always_ff @(posedge ref_clk) begin
      if (!rst_n) up <= 0;
      else if (up < 100000) up <= up + 1;
   end
   // Shadow of the monitor enable, cleared by any reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n || cpu_reset) clock_fail_detect_enable <= 1'b0;
      else if (write && address == 4'h0) clock_fail_detect_enable <= writedata[3];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence pin_pulse;
      reset_pin_oe [*4] ##1 !reset_pin_oe;
   endsequence
   sequence released;
      $fell(reset_pin_oe);
   endsequence
   sequence settings_read;
      read && !write && address == 4'h0;
   endsequence
   sequence one_wait;
      waitrequest ##1 !waitrequest;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   power_hold_a: assert property (
      up < POWER_UP_CYCLES - 1 |-> cpu_reset && !reset_pin_oe)
      else $error("run before the power-up delay");
   pin_pulse_a: assert property ($rose(reset_pin_oe) |-> pin_pulse)
      else $error("pin drive not four cycles");
   pin_low_a: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("pin driven high");
   ext_hold_a: assert property (
      released ##0 !reset_pin_in [*4] |-> cpu_reset)
      else $error("run while pin held low");
   int_run_a: assert property (
      released ##0 reset_pin_in [*4] |-> ##[0:3] !cpu_reset)
      else $error("no run after internal reset");
   no_wait_a: assert property (!read |-> !waitrequest)
      else $error("waitrequest raised");
   read_wait_a: assert property ($rose(read) |-> one_wait)
      else $error("read not answered after one wait");
   read_back_a: assert property (settings_read ##0 !waitrequest |->
      readdata[5] == irq_edge_select && !readdata[2])
      else $error("settings read mismatch");
   edge_set_a: assert property (
      write && address == 4'h0 && !cpu_reset
      |=> irq_edge_select == $past(writedata[5]))
      else $error("edge select not written");
   stop_fail_a: assert property (
      $rose(stop_request) && clock_fail_detect_enable |-> ##[1:400] reset_pin_oe)
      else $error("stop with monitor gave no reset");
endmodule

bind rwm_supervisor rwm_properties #(
   .POWER_UP_CYCLES(POWER_UP_CYCLES)
) i_rwm_properties (
   .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .reset_pin_in(reset_pin_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
   .stop_request(stop_request), .cpu_reset(cpu_reset),
   .irq_edge_select(irq_edge_select));

// [testbench/rwm_reset_circuit.sv]
// External reset circuit with a pull-up on the open-drain pin.
// Assumes the bench commands when the pin is held low.
`timescale 1ns/1ns
module rwm_reset_circuit (
   // Device side
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   // Bench command
   input wire logic hold_low,
   // Wire level
   output logic pin_level
);
   // Pull-up unless either party pulls low
   assign pin_level = !hold_low && (!reset_pin_oe || reset_pin_out);
endmodule

// [testbench/tb.sv]
// Self-checking bench for the reset supervisor.
// Assumes shrunk power-up and watchdog counts via parameters.
`timescale 1ns/1ns
module tb;
   localparam int PU = 16;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic monitor_tick = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, pin_out, pin_oe, pin, cpu_reset, irq_edge_select;
   logic hold_low = 1'b0;
   logic special_mode = 1'b0;
   logic stop_request = 1'b0;
   logic [1:0] reset_cause;
   logic [7:0] rd;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int n, t0;
   ////////////////////////////////////////////////////////////////////////
   // Bus clock and an unrelated monitor reference
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #137;
      forever #500 monitor_tick = ~monitor_tick;
   end
   rwm_supervisor #(.POWER_UP_CYCLES(PU), .WATCHDOG_DIV_LOG2(6))
   i_rwm_supervisor (
      .ref_clk(ref_clk), .rst_n(rst_n), .monitor_tick(monitor_tick),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .reset_pin_in(pin),
      .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
      .special_mode(special_mode), .stop_request(stop_request),
      .cpu_reset(cpu_reset), .reset_cause(reset_cause),
      .irq_edge_select(irq_edge_select));
   rwm_reset_circuit i_rwm_reset_circuit (.reset_pin_out(pin_out),
      .reset_pin_oe(pin_oe), .hold_low(hold_low), .pin_level(pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One bus transfer; read data lands in rd
   task automatic bus(input bit wr, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {24'h0, d};
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // Counts cycles until pin drive (sel 1) or processor run (sel 0)
   task automatic wait_for(input bit sel, input int limit);
      n = 0;
      while ((sel ? pin_oe : !cpu_reset) !== 1'b1 && n < limit) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic power_up();
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      power_up();
      wait_for(1, 200);
      check(n >= PU && n <= PU + 6, 1);
      wait_for(0, 20);
      check(n <= 10, 1);
      check(reset_cause, rwm_pkg::RWM_CAUSE_PIN);
      bus(1, 4'h0, 8'h21);
      bus(1, 4'h0, 8'h07);
      bus(0, 4'h0, 8'h00);
      check(rd, 8'h01);
      bus(0, 4'h2, 8'h00);
      check(rd, 8'h00);
      for (int i = 0; i < 4; i++) begin
         bus(1, 4'h8, 8'h55);
         bus(0, 4'h0, 8'h00);
         bus(1, 4'h8, 8'hAA);
         t0 = cycles;
         wait_for(1, 100);
         check(n, 100);
      end
      for (int i = 0; i < 8 && pin_oe !== 1'b1; i++) begin
         bus(1, 4'h8, 8'hAA);
         wait_for(1, 100);
      end
      check(cycles - t0 >= 120 && cycles - t0 <= 520, 1);
      wait_for(0, 20);
      check(reset_cause, rwm_pkg::RWM_CAUSE_WATCHDOG);
      bus(1, 4'h4, 8'h04);
      bus(0, 4'h0, 8'h00);
      check(rd, 8'h00);
      wait_for(1, 200);
      check(n < 200, 1);
      wait_for(0, 20);
      bus(0, 4'h4, 8'h00);
      check(rd, 8'h04);
      wait_for(1, 600);
      check(n, 600);
      bus(1, 4'h0, 8'h08);
      bus(0, 4'h0, 8'h00);
      check(rd, 8'h08);
      wait_for(1, 300);
      check(n, 300);
      stop_request <= 1'b1;
      wait_for(1, 400);
      check(n < 400, 1);
      stop_request <= 1'b0;
      wait_for(0, 40);
      check(reset_cause, rwm_pkg::RWM_CAUSE_CLOCK_FAIL);
      bus(0, 4'h0, 8'h00);
      check(rd, 8'h00);
      hold_low <= 1'b1;
      repeat (40) @(posedge ref_clk);
      check(cpu_reset, 1);
      hold_low <= 1'b0;
      wait_for(0, 40);
      check(n < 40, 1);
      check(reset_cause, rwm_pkg::RWM_CAUSE_PIN);
      bus(1, 4'h4, 8'h00);
      special_mode <= 1'b1;
      power_up();
      wait_for(0, 200);
      wait_for(1, 300);
      check(n, 300);
      bus(1, 4'h0, 8'h02);
      bus(1, 4'h0, 8'h01);
      bus(0, 4'h0, 8'h00);
      check(rd, 8'h01);
      bus(1, 4'hC, 8'h00);
      wait_for(1, 600);
      check(n < 600, 1);
      results();
   end
endmodule
